// ==== hw/pcs_pkg.sv ====
package pcs_pkg;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } pcs_bus_type;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_READ,
    BUS_WRITE,
    BUS_HIZ
  } pcs_bus_state_type;

endpackage : pcs_pkg

// ==== hw/pcs_regs.sv ====
`timescale 1ns/1ps
`include "pcs_regs_map.svh"

// Summary of operation
// RL1 - crc error tally held as read-only low and high bytes
// RL2 - crc errors not counted while multiframe alignment is lost
// RL3 - 13-bit line violation tally, low byte and high bits 12 to 8
// RL4 - threshold select 0 at reset selects two-thirds slicer threshold
// RL5 - threshold select 1 selects half-amplitude slicer threshold
// RL6 - read-only squelch state bit shows present alarm state
// RL7 - squelch event flag set on every alarm change
// RL8 - reading squelch enable/status register clears the event flag
// RL9 - enabled squelch events drive the active-low interrupt pin
// RL10 - squelch interrupt enable resets to 0
// RL11 - chip select, read and write together float all outputs; only data_oe and irq_oe drop, threshold_select stays driven
// RL12 - test registers live in the upper half of address space
// RL13 - test mode 0 reads input levels and forces outputs
// RL14 - writes to unused bits ignored, those bits read as zero
// RL15 - host masks unused bits in every read value
// RL16 - writable test force bits are not initialised by reset
// RL17 - write to any counter address latches and clears all counters
// RL18 - holding registers loaded within 27 clocks of latch write
// RL19 - squelch request active exactly while flag and enable both set
module pcs_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic irq_out_n,
  output logic irq_oe,
  input wire logic crc_error_event,
  input wire logic line_violation_event,
  input wire logic multiframe_out_of_alignment,
  input wire logic squelch_alarm,
  output logic threshold_select,
  output logic squelch_irq_req
);
  import pcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  pcs_bus_type bus_raw;
  pcs_bus_type bus;
  logic squelch_now;
  logic squelch_prev;

  assign bus_raw = '{cs: ~chip_select_n, rd: ~read_strobe_n, wr: ~write_strobe_n,
                     addr: addr, data: data_in};

  // address and data share the strobes' latency, so they line up again
  pcs_sync #(.WIDTH($bits(pcs_bus_type))) bus_sync_u (
    .mclk(mclk),
    .rst(rst),
    .d(bus_raw),
    .q(bus)
  );

  pcs_sync #(.WIDTH(1)) squelch_sync_u (
    .mclk(mclk),
    .rst(rst),
    .d(squelch_alarm),
    .q(squelch_now)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus cycle tracking

  pcs_bus_state_type state;
  pcs_bus_state_type next_state;
  logic hiz_all;
  logic read_take;
  logic write_take;
  logic is_test_addr;

  assign hiz_all = bus.cs & bus.rd & bus.wr; // RL11
  assign is_test_addr = bus.addr[`PCS_TEST_SPACE_BIT]; // RL12

  always_comb begin
    next_state = state;
    unique case (state)
      BUS_IDLE: begin
        if (hiz_all) next_state = BUS_HIZ;
        else if (bus.cs & bus.rd) next_state = BUS_READ;
        else if (bus.cs & bus.wr) next_state = BUS_WRITE;
      end
      BUS_READ: begin
        if (hiz_all) next_state = BUS_HIZ;
        else if (!(bus.cs & bus.rd)) next_state = BUS_IDLE;
      end
      BUS_WRITE: begin
        if (hiz_all) next_state = BUS_HIZ;
        else if (!(bus.cs & bus.wr)) next_state = BUS_IDLE;
      end
      BUS_HIZ: begin
        if (!bus.cs) next_state = BUS_IDLE;
      end
    endcase
  end

  // each access acts once, on entry, however long the strobe is held
  assign read_take = (state == BUS_IDLE) && (next_state == BUS_READ);
  assign write_take = (state == BUS_IDLE) && (next_state == BUS_WRITE);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) state <= BUS_IDLE;
    else state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // performance counters

  logic perf_write;
  logic latch_pulse;
  logic [`PCS_CRC_WIDTH-1:0] crc_count;
  logic [`PCS_CRC_WIDTH-1:0] crc_hold;
  logic [`PCS_VIOL_WIDTH-1:0] viol_count;
  logic [`PCS_VIOL_WIDTH-1:0] viol_hold;

  assign perf_write = write_take && bus.addr >= `PCS_ADDR_PERF_FIRST
                      && bus.addr <= `PCS_ADDR_PERF_LAST; // RL17

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) latch_pulse <= 1'b0;
    else latch_pulse <= perf_write; // RL18
  end

  pcs_tally #(.WIDTH(`PCS_CRC_WIDTH)) crc_u (
    .mclk(mclk),
    .rst(rst),
    .event_in(crc_error_event),
    .inhibit(multiframe_out_of_alignment), // RL2
    .latch(latch_pulse), // RL17
    .count(crc_count),
    .hold(crc_hold)
  );

  pcs_tally #(.WIDTH(`PCS_VIOL_WIDTH)) viol_u (
    .mclk(mclk),
    .rst(rst),
    .event_in(line_violation_event),
    .inhibit(1'b0),
    .latch(latch_pulse), // RL17
    .count(viol_count),
    .hold(viol_hold)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control and status registers

  logic threshold_bit;
  logic squelch_flag;
  logic squelch_en;
  logic test_mode0;
  logic [1:0] force_val;
  logic next_squelch_flag;
  logic next_squelch_en;
  logic next_req;
  logic squelch_change;
  logic squelch_read_clear;

  assign squelch_change = squelch_now ^ squelch_prev; // RL7
  assign squelch_read_clear = read_take && bus.addr == `PCS_ADDR_SQUELCH_IRQ; // RL8
  // a change in the clearing cycle wins so no edge is lost
  assign next_squelch_flag = squelch_change | (squelch_flag & ~squelch_read_clear); // RL7 RL8
  assign next_squelch_en = (write_take && bus.addr == `PCS_ADDR_SQUELCH_IRQ) ?
                           bus.data[`PCS_BIT_SQUELCH_ENABLE] : squelch_en;
  assign next_req = next_squelch_flag & next_squelch_en; // RL19

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      threshold_bit <= `PCS_RST_THRESHOLD_SEL; // RL4
      squelch_en <= `PCS_RST_SQUELCH_ENABLE; // RL10
      squelch_flag <= 1'b0;
      squelch_prev <= 1'b0;
      test_mode0 <= `PCS_RST_TEST_MODE0;
    end else begin
      squelch_prev <= squelch_now;
      squelch_flag <= next_squelch_flag;
      squelch_en <= next_squelch_en;
      // only bit 0 of each control byte is stored, the rest are dropped
      if (write_take && bus.addr == `PCS_ADDR_SLICER_CFG) begin
        threshold_bit <= bus.data[`PCS_BIT_THRESHOLD_SEL]; // RL14
      end
      if (write_take && is_test_addr && bus.addr == `PCS_ADDR_TEST_CTRL) begin
        test_mode0 <= bus.data[`PCS_BIT_TEST_MODE0]; // RL13
      end
    end
  end

  // force bits have no reset, software must load them before test mode
  always_ff @(posedge mclk) begin
    if (write_take && is_test_addr && bus.addr == `PCS_ADDR_TEST_IO) begin
      force_val <= bus.data[1:0]; // RL16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  logic [7:0] read_data;
  logic [7:0] test_levels;

  assign test_levels = {4'h0, multiframe_out_of_alignment, line_violation_event,
                        crc_error_event, squelch_now};

  always_comb begin
    read_data = 8'h00; // RL14
    unique case (bus.addr)
      `PCS_ADDR_CRC_LOW: read_data = crc_hold[7:0]; // RL1
      `PCS_ADDR_CRC_HIGH: read_data = {6'h00, crc_hold[9:8]}; // RL1
      `PCS_ADDR_VIOL_LOW: read_data = viol_hold[7:0]; // RL3
      `PCS_ADDR_VIOL_HIGH: read_data = {3'h0, viol_hold[12:8]}; // RL3
      `PCS_ADDR_SLICER_CFG: read_data = {7'h00, threshold_bit};
      `PCS_ADDR_SQUELCH_IRQ: read_data = {5'h00, squelch_now, squelch_flag, squelch_en}; // RL6
      `PCS_ADDR_TEST_CTRL: read_data = {7'h00, test_mode0};
      // levels of the inputs are only visible in test mode 0
      `PCS_ADDR_TEST_IO: read_data = test_mode0 ? test_levels : {6'h00, force_val}; // RL13
      default: read_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // output flops

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      irq_out_n <= 1'b1;
      irq_oe <= 1'b0;
      threshold_select <= 1'b0;
      squelch_irq_req <= 1'b0;
    end else begin
      if (read_take) data_out <= read_data;
      data_oe <= (next_state == BUS_READ); // RL11
      squelch_irq_req <= next_req; // RL19
      if (test_mode0) begin
        irq_out_n <= ~force_val[`PCS_BIT_FORCE_IRQ]; // RL13
        threshold_select <= force_val[`PCS_BIT_FORCE_THRESHOLD]; // RL13
      end else begin
        irq_out_n <= ~next_req; // RL9
        threshold_select <= threshold_bit; // RL4 RL5
      end
      // open drain: driven only while pulled low and not floated
      irq_oe <= (next_state != BUS_HIZ) &
                (test_mode0 ? force_val[`PCS_BIT_FORCE_IRQ] : next_req); // RL11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_crc_suppress: assert property ( // RL2
    multiframe_out_of_alignment && !latch_pulse |=> crc_count == $past(crc_count))
    else $error("crc tally moved while multiframe alignment lost");

  chk_latch_clear: assert property ( // RL17
    perf_write |=> latch_pulse ##1 (crc_count == '0 && viol_count == '0))
    else $error("counter latch did not clear counters");

  chk_latch_delay: assert property ( // RL18
    perf_write |-> ##[1:27] latch_pulse)
    else $error("holding registers not loaded in time");

  chk_viol_high: assert property ( // RL3
    read_take && bus.addr == `PCS_ADDR_VIOL_HIGH |=> data_out == {3'h0, $past(viol_hold[12:8])})
    else $error("line violation high byte wrong");

  chk_thresh_half: assert property ( // RL5
    threshold_bit && !test_mode0 |=> threshold_select)
    else $error("half threshold not selected");

  chk_thresh_two_thirds: assert property ( // RL4
    !threshold_bit && !test_mode0 |=> !threshold_select)
    else $error("two-thirds threshold not selected");

  chk_squelch_set: assert property ( // RL7
    squelch_change |=> squelch_flag)
    else $error("squelch change did not set flag");

  chk_squelch_clear: assert property ( // RL8
    squelch_read_clear && !squelch_change |=> !squelch_flag)
    else $error("squelch read did not clear flag");

  chk_irq_pin: assert property ( // RL9
    !$past(test_mode0) |-> irq_out_n == !(squelch_flag && squelch_en))
    else $error("interrupt pin disagrees with flag and enable");

  chk_req_exact: assert property ( // RL19
    squelch_irq_req == (squelch_flag && squelch_en))
    else $error("squelch request not equal to flag and enable");

  chk_hiz_bus: assert property ( // RL11
    state == BUS_HIZ |-> !data_oe && !irq_oe)
    else $error("outputs driven during float combination");

  chk_en_reset: assert property ( // RL10
    @(posedge mclk) $fell(rst) |-> !squelch_en)
    else $error("squelch enable not cleared by reset");

  chk_test_force: assert property ( // RL13
    $past(test_mode0) |-> irq_out_n == !$past(force_val[0]))
    else $error("test mode did not force interrupt pin");

  cov_latch_read: cover property (perf_write ##[1:40] read_take);
  cov_squelch_irq: cover property (squelch_change && squelch_en ##1 !irq_out_n);
  cov_hiz: cover property (state == BUS_HIZ);
  cov_test_mode: cover property (test_mode0 && read_take && bus.addr == `PCS_ADDR_TEST_IO);

endmodule : pcs_regs

// ==== hw/pcs_regs_map.svh ====
`ifndef PCS_REGS_MAP_SVH
`define PCS_REGS_MAP_SVH

// register offsets, normal space
`define PCS_ADDR_PERF_FIRST 8'h49
`define PCS_ADDR_PERF_LAST 8'h4f
`define PCS_ADDR_CRC_LOW 8'h4c
`define PCS_ADDR_CRC_HIGH 8'h4d
`define PCS_ADDR_VIOL_LOW 8'h4e
`define PCS_ADDR_VIOL_HIGH 8'h4f
`define PCS_ADDR_SLICER_CFG 8'h5c
`define PCS_ADDR_SQUELCH_IRQ 8'h5d

// test space occupies the upper half
`define PCS_TEST_SPACE_BIT 7
`define PCS_ADDR_TEST_CTRL 8'h80
`define PCS_ADDR_TEST_IO 8'h81

// field positions
`define PCS_BIT_THRESHOLD_SEL 0
`define PCS_BIT_SQUELCH_ENABLE 0
`define PCS_BIT_SQUELCH_FLAG 1
`define PCS_BIT_SQUELCH_STATE 2
`define PCS_BIT_TEST_MODE0 0
`define PCS_BIT_FORCE_IRQ 0
`define PCS_BIT_FORCE_THRESHOLD 1

// reset values
`define PCS_RST_THRESHOLD_SEL 1'b0
`define PCS_RST_SQUELCH_ENABLE 1'b0
`define PCS_RST_TEST_MODE0 1'b0

// counter widths and timing
`define PCS_CRC_WIDTH 10
`define PCS_VIOL_WIDTH 13
`define PCS_LATCH_MAX_CYCLES 27

`endif

// ==== hw/pcs_sync.sv ====
`timescale 1ns/1ps

module pcs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // meta is read only by the second stage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : pcs_sync

// ==== hw/pcs_tally.sv ====
`timescale 1ns/1ps

module pcs_tally #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic event_in,
  input wire logic inhibit,
  input wire logic latch,
  output logic [WIDTH-1:0] count,
  output logic [WIDTH-1:0] hold
);

  logic counted;
  logic [WIDTH-1:0] sum;

  assign counted = event_in & ~inhibit;
  // saturate rather than wrap so a long interval never reads small
  assign sum = (&count) ? count : count + WIDTH'(counted);

  // the event of the latch cycle goes into the held value, none is lost
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= '0;
      hold <= '0;
    end else if (latch) begin
      hold <= sum;
      count <= '0;
    end else begin
      count <= sum;
    end
  end

endmodule : pcs_tally

// ==== sim/pcs_host_model.sv ====
`timescale 1ns/1ps
// host on the register pins; everything moves just after a rising edge
module pcs_host_model (
  input wire logic mclk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [7:0] addr,
  output logic [7:0] data_in
);
  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    addr = 8'h00;
    data_in = 8'h00;
  end
  ////////////////////////////////////////
  task automatic setup(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    data_in <= d;
    // address must be settled two edges before the strobe
    repeat (2) @(posedge mclk);
  endtask : setup
  task automatic release_bus();
    chip_select_n <= 1'b1;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    // released lines must not keep showing the old value
    addr <= ~addr;
    data_in <= ~data_in;
    repeat (3) @(posedge mclk);
  endtask : release_bus
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    setup(a, d);
    chip_select_n <= 1'b0;
    write_strobe_n <= 1'b0;
    repeat (4) @(posedge mclk);
    release_bus();
  endtask : bus_write
  task automatic bus_read(input logic [7:0] a, input logic [7:0] mask,
                          output logic [7:0] d, output logic ok);
    setup(a, 8'h00);
    chip_select_n <= 1'b0;
    read_strobe_n <= 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 12 && ok !== 1'b1; i++) begin
      @(posedge mclk);
      if (data_oe === 1'b1) begin
        d = data_out & mask;
        ok = 1'b1;
      end
    end
    release_bus();
  endtask : bus_read
  task automatic float_on();
    @(posedge mclk);
    chip_select_n <= 1'b0;
    read_strobe_n <= 1'b0;
    write_strobe_n <= 1'b0;
  endtask : float_on
  task automatic float_off();
    release_bus();
  endtask : float_off
endmodule : pcs_host_model

// ==== sim/pcs_regs_tb.sv ====
`timescale 1ns/1ps
module pcs_regs_tb;
  logic mclk, rst, crc_ev, viol_ev, mfoa, squelch_in;
  logic cs_n, rd_n, wr_n, doe, irq_n, irq_oe, thr_sel, squelch_req;
  logic [7:0] a, din, dout;
  int miscompares = 0;
  int check_count = 0;
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  pcs_regs dut (.mclk(mclk), .rst(rst), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .addr(a), .data_in(din), .data_out(dout), .data_oe(doe),
    .irq_out_n(irq_n), .irq_oe(irq_oe), .crc_error_event(crc_ev),
    .line_violation_event(viol_ev), .multiframe_out_of_alignment(mfoa),
    .squelch_alarm(squelch_in), .threshold_select(thr_sel), .squelch_irq_req(squelch_req));
  pcs_host_model host (.mclk(mclk), .data_out(dout), .data_oe(doe), .chip_select_n(cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .addr(a), .data_in(din));
  ////////////////////////////////////////
  task automatic complete_run();
    $display("miscompares %0d check_count %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.bus_read(ad, m, d, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, ok, 1'b1);
      complete_run();
    end else
      check(d, exp);
  endtask : rd
  task automatic wait_req(input logic exp);
    int i;
    for (i = 0; i < 12 && squelch_req !== exp; i++) @(posedge mclk);
    if (i == 12) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, squelch_req, exp);
      complete_run();
    end
  endtask : wait_req
  task automatic pulses(input int n_crc, input int n_lcv);
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      crc_ev <= (i < n_crc);
      viol_ev <= (i < n_lcv);
    end
    @(posedge mclk);
    crc_ev <= 1'b0;
    viol_ev <= 1'b0;
  endtask : pulses
  ////////////////////////////////////////
  task automatic reset_values();
    check({7'h00, thr_sel}, 8'h00);
    check({7'h00, irq_n}, 8'h01);
    rd(8'h5d, 8'h01, 8'h00);
    rd(8'h5c, 8'h01, 8'h00);
  endtask : reset_values
  task automatic threshold_cfg();
    host.bus_write(8'h5c, 8'hff);
    check({7'h00, thr_sel}, 8'h01);
    rd(8'h5c, 8'h01, 8'h01);
    host.bus_write(8'h5c, 8'h00);
    check({7'h00, thr_sel}, 8'h00);
  endtask : threshold_cfg
  task automatic counters();
    host.bus_write(8'h4f, 8'h00);
    pulses(260, 300);
    mfoa <= 1'b1;
    pulses(9, 0);
    mfoa <= 1'b0;
    host.bus_write(8'h49, 8'h00);
    repeat (27) @(posedge mclk);
    rd(8'h4c, 8'hff, 8'h04);
    rd(8'h4d, 8'h03, 8'h01);
    rd(8'h4e, 8'hff, 8'h2c);
    rd(8'h4f, 8'h1f, 8'h01);
    host.bus_write(8'h4e, 8'h00);
    repeat (27) @(posedge mclk);
    rd(8'h4e, 8'hff, 8'h00);
  endtask : counters
  task automatic squelch();
    host.bus_write(8'h5d, 8'h01);
    squelch_in <= 1'b1;
    wait_req(1'b1);
    check({7'h00, irq_n}, 8'h00);
    rd(8'h5d, 8'h07, 8'h07);
    check({7'h00, squelch_req}, 8'h00);
    squelch_in <= 1'b0;
    wait_req(1'b1);
    rd(8'h5d, 8'h07, 8'h03);
    host.bus_write(8'h5d, 8'h00);
    squelch_in <= 1'b1;
    repeat (8) @(posedge mclk);
    check({6'h00, irq_n, squelch_req}, 8'h02);
    rd(8'h5d, 8'h07, 8'h06);
  endtask : squelch
  task automatic float_pins();
    host.bus_write(8'h5d, 8'h01);
    squelch_in <= 1'b0;
    wait_req(1'b1);
    check({7'h00, irq_oe}, 8'h01);
    host.float_on();
    repeat (5) @(posedge mclk);
    check({6'h00, doe, irq_oe}, 8'h00);
    host.float_off();
    rd(8'h5d, 8'h07, 8'h03);
    host.bus_write(8'h5d, 8'h00);
  endtask : float_pins
  task automatic test_mode();
    mfoa <= 1'b1;
    squelch_in <= 1'b1;
    // force bits power up unknown, so load them before entering the mode
    host.bus_write(8'h81, 8'h00);
    host.bus_write(8'h00, 8'h01);
    rd(8'h80, 8'h01, 8'h00);
    host.bus_write(8'h80, 8'h01);
    rd(8'h80, 8'h01, 8'h01);
    rd(8'h81, 8'h0f, 8'h09);
    host.bus_write(8'h81, 8'h01);
    check({6'h00, irq_oe, irq_n}, 8'h02);
    host.bus_write(8'h81, 8'h02);
    check({6'h00, thr_sel, irq_n}, 8'h03);
    host.bus_write(8'h81, 8'h00);
    host.bus_write(8'h80, 8'h00);
    mfoa <= 1'b0;
    rd(8'h30, 8'hff, 8'h00);
  endtask : test_mode
  task automatic reset_again();
    host.bus_write(8'h5c, 8'h01);
    host.bus_write(8'h5d, 8'h01);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check({6'h00, thr_sel, irq_n}, 8'h01);
    rd(8'h5d, 8'h01, 8'h00);
  endtask : reset_again
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    crc_ev = 1'b0;
    mfoa = 1'b0;
    viol_ev = 1'b0;
    squelch_in = 1'b0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    reset_values();
    threshold_cfg();
    counters();
    squelch();
    float_pins();
    test_mode();
    reset_again();
    complete_run();
  end
endmodule : pcs_regs_tb
